// File: bench/catc_ca_term_ctrl_assertions.sv
/* Port checker of the termination control block.
   Assumes binding onto catc_ca_term_ctrl by the statement at the end. */
`timescale 1ns/100ps
`default_nettype none
`include "catc_defines.svh"
module catc_ca_term_ctrl_assertions
    import catc_pkg::*;
#(
    parameter int TZQCAL_NS = `CATC_TZQCAL_NS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB
    input wire catc_apb_req_t apb_req,
    input wire catc_apb_rsp_t apb_rsp,
    // Pins
    input wire logic ca_termination_strap,
    input wire logic power_down,
    // Termination
    input wire catc_term_t term_en,
    input wire logic [2:0] term_code,
    input wire logic calib_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence access_s;
        apb_req.psel && apb_req.penable && !apb_rsp.pready;
    endsequence
    sequence cfg_done_s;
        apb_rsp.pready && apb_req.pwrite && !apb_rsp.pslverr &&
            apb_req.paddr == `CATC_OFS_CONFIG;
    endsequence
    ready_answer_a:
        assert property (access_s |=> apb_rsp.pready)
        else $error("no pready after access");
    ready_pulse_a:
        assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready too long");
    err_qual_a:
        assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr without pready");
    code_write_a:
        assert property (cfg_done_s |=>
            term_code == $past(apb_req.pwdata[6:4]))
        else $error("code not taken");
    reset_off_a:
        assert property ($rose(rstn) |-> term_en == '0 && term_code == 3'h0)
        else $error("termination on after reset");
    code_off_a:
        assert property (!(term_code inside {[3'h1:3'h6]}) |=> term_en == '0)
        else $error("termination on with bad code");
    cmd_group_a:
        assert property (term_en.cmd_lines inside {6'h00, 6'h3F})
        else $error("command lines split");
    strap_gate_a:
        assert property (!ca_termination_strap |-> term_en.cmd_lines == 6'h00)
        else $error("terminated with strap low");
    pd_hold_a:
        assert property ($rose(power_down) && !apb_req.psel |=>
            $stable(term_en) [*4])
        else $error("power-down changed termination");
    // Busy cycles counted against the calibration time
    localparam int CAL_CYC_I = TZQCAL_NS / `CATC_CLK_NS;
    localparam int CAL_CYC = (CAL_CYC_I < 1) ? 1 : CAL_CYC_I;
    logic [15:0] busy_cnt_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy_cnt_q <= 16'h0000;
        end else if (calib_busy) begin
            busy_cnt_q <= busy_cnt_q + 16'h0001;
        end else begin
            busy_cnt_q <= 16'h0000;
        end
    end
    busy_len_a:
        assert property ($fell(calib_busy) |-> busy_cnt_q == 16'(CAL_CYC))
        else $error("calibration length wrong");
endmodule
bind catc_ca_term_ctrl catc_ca_term_ctrl_assertions #(
    .TZQCAL_NS(TZQCAL_NS)
) u_chk (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .ca_termination_strap(ca_termination_strap),
    .power_down(power_down),
    .term_en(term_en),
    .term_code(term_code),
    .calib_busy(calib_busy)
);
`default_nettype wire

// File: bench/catc_ctrl_model.sv
/* Controller model: APB master writing the mode fields.
   Assumes catc_pkg compiled first; used only after reset release. */
`timescale 1ns/100ps
`default_nettype none
module catc_ctrl_model
    import catc_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // APB
    output catc_apb_req_t apb_req,
    input wire catc_apb_rsp_t apb_rsp
);
    logic hung = 1'b0;
    initial apb_req = '0;
    // Released lines carry inverted values
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge sys_clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        hung = (n >= 50);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '{1'b0, 1'b0, ~w, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// File: bench/tb_catc_ca_term_ctrl.sv
/* Self-checking bench of the termination control block.
   Assumes design, checker and controller model compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "catc_defines.svh"
module tb_catc_ca_term_ctrl
    import catc_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic strap = 1'b1;
    logic power_down = 1'b0;
    catc_apb_req_t req;
    catc_apb_rsp_t rsp;
    catc_term_t term_en;
    logic [2:0] term_code;
    logic calib_busy;
    logic [31:0] q;
    logic e;
    int failures = 0;
    int comparisons = 0;
    catc_ctrl_model ctrl (.sys_clk(sys_clk), .apb_req(req), .apb_rsp(rsp));
    catc_ca_term_ctrl #(.TZQCAL_NS(250)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
        .ca_termination_strap(strap), .power_down(power_down),
        .term_en(term_en), .term_code(term_code), .calib_busy(calib_busy)
    );
    initial forever #12.5 sys_clk = ~sys_clk;
    // ****
    // Helpers
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        ctrl.xfer(w, a, d, q, e);
        if (ctrl.hung) begin
            failures++;
            final_report();
        end
    endtask
    function automatic catc_term_t exp_term(logic s, logic [2:0] c,
        logic [2:0] o);
        catc_term_t t;
        t = '0;
        if (c inside {[3'h1:3'h6]}) begin
            t.clk_pair = s | o[0];
            t.chip_sel = s | o[1];
            t.cmd_lines = (s && !o[2]) ? 6'h3F : 6'h00;
        end
        return t;
    endfunction
    task automatic rst(input logic s);
        @(posedge sys_clk);
        rstn <= 1'b0;
        strap <= s;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask
    // Code follows a write one edge later, termination two
    task automatic settle();
        repeat (2) @(negedge sys_clk);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        chk(32'(term_en), 32'h0);
        bus(1'b0, `CATC_OFS_OVERRIDE, '0);
        chk(q, 32'h0);
    endtask
    // Pull-up point stays low, so every code is allowed
    task automatic t_codes(input logic s);
        for (int c = 0; c < 8; c++) begin
            for (int o = 0; o < 8; o++) begin
                bus(1'b1, `CATC_OFS_CONFIG, 32'(c) << 4);
                bus(1'b1, `CATC_OFS_OVERRIDE, 32'(o) << 3);
                settle();
                chk(32'(term_code), 32'(c));
                chk(32'(term_en), 32'(exp_term(s, 3'(c), 3'(o))));
            end
        end
    endtask
    task automatic t_power();
        bus(1'b1, `CATC_OFS_CONFIG, 32'h30);
        bus(1'b1, `CATC_OFS_OVERRIDE, 32'h0);
        @(posedge sys_clk);
        power_down <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk(32'(term_en), 32'(exp_term(1'b1, 3'h3, 3'h0)));
        power_down <= 1'b0;
    endtask
    task automatic t_calib();
        bus(1'b1, `CATC_OFS_CALIB, 32'h1);
        bus(1'b0, `CATC_OFS_STATUS, '0);
        chk(32'(q[4:0]), 32'h0D);
        bus(1'b1, `CATC_OFS_CALIB, 32'h3);
        bus(1'b0, `CATC_OFS_STATUS, '0);
        chk(32'(q[4:0]), 32'h0F);
        chk(32'(calib_busy), 32'h1);
        // Code left alone until calibration ends
        for (int i = 0; i < 20 && q[1]; i++) begin
            bus(1'b0, `CATC_OFS_STATUS, '0);
        end
        chk(32'(q[4:0]), 32'h09);
        chk(32'(calib_busy), 32'h0);
        bus(1'b1, `CATC_OFS_CONFIG, 32'h20);
        settle();
        chk(32'(term_code), 32'h2);
    endtask
    task automatic t_refuse();
        bus(1'b1, 12'h010, 32'h70);
        chk(32'(e), 32'h1);
        bus(1'b1, `CATC_OFS_STATUS, 32'h1F);
        bus(1'b0, `CATC_OFS_STATUS, '0);
        chk(32'(q[4:0]), 32'h09);
        chk(32'(term_code), 32'h2);
    endtask
    // Terminating rank is set up first, the other afterwards
    initial begin
        rst(1'b1);
        t_reset();
        t_codes(1'b1);
        t_power();
        t_calib();
        t_refuse();
        rst(1'b0);
        t_codes(1'b0);
        final_report();
    end
endmodule
`default_nettype wire

// File: logic/catc_ca_term_ctrl.sv
/*
 * Command/address bus termination control: mode fields reached over APB,
 * strap sampling, per-signal enables, calibration tracking.
 * Assumes an APB master on sys_clk and a strap pin that is static.
 */
// The address map and the APB register port were chosen for this implementation.
// Function
// - Three-bit code 1..6 selects 240,120,80,60,48,40 ohm termination.
// - After reset the code is zero, so termination stays off.
// - Enabled termination covers clock pair, chip select, six CA lines.
// - Power-down and self-refresh leave termination untouched.
// - Strap low: command lines never terminated, whatever the code.
// - Strap high with code 1..6: terminate with the coded value; here OVERRIDE bit 5 set leaves the command lines off.
// - Sampled strap is not re-sampled on power-down entry.
// - Code may change after calibration; device accepts it at once.
`timescale 1ns/100ps
`default_nettype none
`include "catc_defines.svh"

module catc_ca_term_ctrl
    import catc_pkg::*;
#(
    parameter int TZQCAL_NS = `CATC_TZQCAL_NS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB slave
    input wire catc_apb_req_t apb_req,
    output catc_apb_rsp_t apb_rsp,
    // Pins and power state
    input wire logic ca_termination_strap,
    input wire logic power_down,
    // Termination drive
    output catc_term_t term_en,
    output logic [2:0] term_code,
    output logic calib_busy
);

    localparam int CAL_CYC_I = TZQCAL_NS / `CATC_CLK_NS;
    localparam int CAL_CYC = (CAL_CYC_I < 1) ? 1 : CAL_CYC_I;
    localparam logic [15:0] CAL_CYC_W = CAL_CYC[15:0];

    // Refuse a calibration time that the 16-bit counter cannot hold
    if (CAL_CYC > 65535) begin
        $error("catc: calibration time too long for counter");
    end

    // ****************************************************************
    // Strap synchroniser and one-shot capture
    // ****************************************************************
    logic strap_s1_q, strap_s2_q, strap_q, strap_d;
    logic [1:0] strap_cnt_q, strap_cnt_d;

    always_comb begin
        strap_d = strap_q;
        strap_cnt_d = strap_cnt_q;
        // Let the synchroniser fill before the single capture
        if (strap_cnt_q != 2'h3) begin
            strap_cnt_d = strap_cnt_q + 2'h1;
        end
        // Captured once after reset; power-down never re-samples
        if (strap_cnt_q == 2'h2) begin
            strap_d = strap_s2_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
            strap_q <= 1'b0;
            strap_cnt_q <= 2'h0;
        end else begin
            strap_s1_q <= ca_termination_strap;
            strap_s2_q <= strap_s1_q;
            strap_q <= strap_d;
            strap_cnt_q <= strap_cnt_d;
        end
    end

    // ****************************************************************
    // Registers and APB slave
    // ****************************************************************
    logic [2:0] code_q, code_d;
    logic [2:0] ovr_q, ovr_d;
    logic pu_high_q, pu_high_d;
    logic recal_q, recal_d;
    catc_cal_state_t cal_q, cal_d;
    logic [15:0] cal_cnt_q, cal_cnt_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic wr, rd, acc, ack_q, mapped;
    logic code_valid, forbidden_setting;

    // Writes land at the ready edge; reads are captured one edge before
    assign acc = apb_req.psel && apb_req.penable;
    assign wr = acc && apb_req.pwrite && ack_q;
    assign rd = acc && !apb_req.pwrite && !ack_q;
    assign mapped = apb_req.paddr == `CATC_OFS_CONFIG ||
        apb_req.paddr == `CATC_OFS_OVERRIDE ||
        apb_req.paddr == `CATC_OFS_CALIB ||
        apb_req.paddr == `CATC_OFS_STATUS;

    always_comb begin
        code_d = code_q;
        ovr_d = ovr_q;
        pu_high_d = pu_high_q;
        recal_d = recal_q;
        cal_d = cal_q;
        cal_cnt_d = cal_cnt_q;
        rdata_d = rdata_q;
        err_d = acc && !ack_q && !mapped;
        case (cal_q)
            CATC_CAL_IDLE: begin
                cal_cnt_d = 16'h0000;
            end
            CATC_CAL_BUSY: begin
                if (cal_cnt_q == CAL_CYC_W - 16'h0001) begin
                    cal_d = CATC_CAL_IDLE;
                    recal_d = 1'b0;
                end else begin
                    cal_cnt_d = cal_cnt_q + 16'h0001;
                end
            end
            default: begin
                cal_d = CATC_CAL_IDLE;
            end
        endcase
        if (wr) begin
            case (apb_req.paddr)
                `CATC_OFS_CONFIG: begin
                    // Takes effect with no calibration needed
                    code_d = apb_req.pwdata[`CATC_CFG_CODE_MSB:
                        `CATC_CFG_CODE_LSB];
                end
                `CATC_OFS_OVERRIDE: begin
                    ovr_d = apb_req.pwdata[`CATC_OVR_CMD_BIT:
                        `CATC_OVR_CK_BIT];
                end
                `CATC_OFS_CALIB: begin
                    if (apb_req.pwdata[`CATC_CAL_PU_BIT] != pu_high_q) begin
                        recal_d = 1'b1;
                    end
                    pu_high_d = apb_req.pwdata[`CATC_CAL_PU_BIT];
                    // A start during a running calibration is ignored
                    if (apb_req.pwdata[`CATC_CAL_START_BIT] &&
                        cal_q == CATC_CAL_IDLE) begin
                        cal_d = CATC_CAL_BUSY;
                    end
                end
                `CATC_OFS_STATUS: begin
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            rdata_d = 32'h0000_0000;
            case (apb_req.paddr)
                `CATC_OFS_CONFIG: begin
                    rdata_d[`CATC_CFG_CODE_MSB:`CATC_CFG_CODE_LSB] = code_q;
                end
                `CATC_OFS_OVERRIDE: begin
                    rdata_d[`CATC_OVR_CMD_BIT:`CATC_OVR_CK_BIT] = ovr_q;
                end
                `CATC_OFS_CALIB: begin
                    rdata_d[`CATC_CAL_PU_BIT] = pu_high_q;
                end
                `CATC_OFS_STATUS: begin
                    rdata_d[0] = strap_q;
                    rdata_d[1] = cal_q == CATC_CAL_BUSY;
                    rdata_d[2] = recal_q;
                    rdata_d[3] = |term_en;
                    rdata_d[4] = forbidden_setting;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            code_q <= `CATC_CODE_RST;
            ovr_q <= `CATC_OVR_RST;
            pu_high_q <= 1'b0;
            recal_q <= 1'b0;
            cal_q <= CATC_CAL_IDLE;
            cal_cnt_q <= 16'h0000;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            code_q <= code_d;
            ovr_q <= ovr_d;
            pu_high_q <= pu_high_d;
            recal_q <= recal_d;
            cal_q <= cal_d;
            cal_cnt_q <= cal_cnt_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // Answer one cycle into the access phase
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc && !ack_q;
        end
    end

    // Ready stands one cycle; the error is decoded at the first access edge
    assign apb_rsp.pready = ack_q;
    assign apb_rsp.pslverr = ack_q && err_q;
    assign apb_rsp.prdata = rdata_q;

    // ****************************************************************
    // Termination decision
    // ****************************************************************
    assign code_valid = code_q != 3'h0 && code_q <= `CATC_CODE_MAX;
    assign forbidden_setting = pu_high_q && code_q > `CATC_CODE_80;

    // power_down is deliberately not a term: termination stays on
    catc_term_t term_d, term_q;
    always_comb begin
        term_d = '0;
        if (code_valid) begin
            if (strap_q) begin
                term_d.clk_pair = 1'b1;
                term_d.chip_sel = 1'b1;
                term_d.cmd_lines = ovr_q[2] ? 6'h00 : 6'h3F;
            end else begin
                term_d.clk_pair = ovr_q[0];
                term_d.chip_sel = ovr_q[1];
                term_d.cmd_lines = 6'h00;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            term_q <= '0;
        end else begin
            term_q <= term_d;
        end
    end

    assign term_en = term_q;
    assign term_code = code_q;
    assign calib_busy = cal_q == CATC_CAL_BUSY;

    logic unused_pd;
    assign unused_pd = power_down;

endmodule

`default_nettype wire

// File: logic/catc_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * command/address termination control block.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef CATC_DEFINES_SVH
`define CATC_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CATC_OFS_CONFIG 12'h000
`define CATC_OFS_OVERRIDE 12'h004
`define CATC_OFS_CALIB 12'h008
`define CATC_OFS_STATUS 12'h00C

// ****************************************************************
// Field positions
// ****************************************************************
`define CATC_CFG_CODE_LSB 4
`define CATC_CFG_CODE_MSB 6
`define CATC_OVR_CK_BIT 3
`define CATC_OVR_CS_BIT 4
`define CATC_OVR_CMD_BIT 5
`define CATC_CAL_PU_BIT 0
`define CATC_CAL_START_BIT 1

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define CATC_CODE_RST 3'h0
`define CATC_CODE_MAX 3'h6
`define CATC_CODE_80 3'h3
`define CATC_OVR_RST 3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define CATC_TZQCAL_NS 1000
`define CATC_CLK_NS 25

`endif

// File: logic/catc_pkg.sv
/*
 * Types of the command/address termination control block.
 * Assumes catc_defines.svh is on the include path.
 */
`default_nettype none
`include "catc_defines.svh"

package catc_pkg;

    // APB request from the bus
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } catc_apb_req_t;

    // APB answer to the bus
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } catc_apb_rsp_t;

    // Per-signal termination enables
    typedef struct packed {
        logic clk_pair;
        logic chip_sel;
        logic [5:0] cmd_lines;
    } catc_term_t;

    typedef enum logic {CATC_CAL_IDLE, CATC_CAL_BUSY} catc_cal_state_t;

endpackage

`default_nettype wire
